// >>> hdl/blcc_pkg.sv
/*
 * Package for the black level calibration controller: register indices,
 * field positions, reset values, threshold constants and sweep timing.
 * Assumes a 16-bit register port and a single sensor master clock.
 */
package blcc_pkg;

  // Register indices on the plain register port
  localparam logic [7:0] BLCC_ADDR_CTRL   = 8'h62;
  localparam logic [7:0] BLCC_ADDR_THRES  = 8'h5F;
  localparam logic [7:0] BLCC_ADDR_GAIN0  = 8'h2B;
  localparam logic [7:0] BLCC_ADDR_GAIN1  = 8'h2C;
  localparam logic [7:0] BLCC_ADDR_GAIN2  = 8'h2D;
  localparam logic [7:0] BLCC_ADDR_GAIN3  = 8'h2E;
  localparam logic [7:0] BLCC_ADDR_STATUS = 8'h60;

  // Threshold register fields
  localparam int BLCC_THR_AUTOHI_BIT = 15;
  localparam int BLCC_THR_HI_MSB     = 14;
  localparam int BLCC_THR_HI_LSB     = 8;
  localparam int BLCC_THR_OVR_BIT    = 7;
  localparam int BLCC_THR_LO_MSB     = 5;
  localparam int BLCC_THR_LO_LSB     = 0;
  localparam logic [15:0] BLCC_THR_MASK = 16'hFFBF;

  // Control register fields
  localparam int BLCC_CTL_NOSWEEP_BIT = 15;
  localparam int BLCC_CTL_RSVD_BIT    = 14;
  localparam int BLCC_CTL_RESTART_BIT = 12;
  localparam int BLCC_CTL_NOHIRST_BIT = 11;
  localparam int BLCC_CTL_MODE_BIT    = 0;
  localparam logic [15:0] BLCC_CTL_MASK = 16'h8801;

  // Reset values
  localparam logic [15:0] BLCC_THR_RESET  = 16'h0000;
  localparam logic [15:0] BLCC_CTL_RESET  = 16'h0000;
  localparam logic [7:0]  BLCC_GAIN_RESET = 8'h08;

  // Upper and lower threshold computation constants
  localparam logic [7:0] BLCC_LVL_SMALL_LIM = 8'h40;
  localparam logic [7:0] BLCC_LVL_MID_LO    = 8'h3F;
  localparam logic [7:0] BLCC_LVL_MID_HI    = 8'h77;
  localparam logic [7:0] BLCC_HI_FIXED      = 8'h7B;
  localparam logic [7:0] BLCC_HI_SMALL_ADD  = 8'h02;
  localparam logic [7:0] BLCC_HI_MID_ADD    = 8'h04;
  localparam logic [7:0] BLCC_HI_RST_ADD    = 8'h05;
  localparam int         BLCC_LO_DIV_SHIFT  = 2;

  // Sweep timing
  localparam int BLCC_CLK_HZ        = 10_000_000;
  localparam int BLCC_SWEEP_US      = 10;
  localparam int BLCC_SWEEP_CYCLES  = (BLCC_SWEEP_US * (BLCC_CLK_HZ / 1_000_000));

  typedef enum logic [1:0] {
    BLCC_ST_IDLE  = 2'b00,
    BLCC_ST_SWEEP = 2'b01,
    BLCC_ST_DONE  = 2'b10
  } blcc_state_t;

endpackage

// >>> hdl/blcc_gain_max.sv
/*
 * Largest of four gain settings and the lower threshold derived from it.
 * Result is registered; assumes gains are stable inputs on clk_in.
 */
module blcc_gain_max
  import blcc_pkg::*;
#(
  parameter int GAIN_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic [GAIN_W-1:0] gain0_in,
  input  wire logic [GAIN_W-1:0] gain1_in,
  input  wire logic [GAIN_W-1:0] gain2_in,
  input  wire logic [GAIN_W-1:0] gain3_in,
  output logic      [GAIN_W-1:0] gain_max_out,
  output logic      [5:0]        lower_auto_out
);

  function automatic logic [GAIN_W-1:0] blcc_max2(input logic [GAIN_W-1:0] a,
                                                   input logic [GAIN_W-1:0] b);
    blcc_max2 = (a > b) ? a : b;
  endfunction

  logic [GAIN_W-1:0] mx;
  logic [9:0]        prod;

  always_comb begin
    mx   = blcc_max2(blcc_max2(gain0_in, gain1_in), blcc_max2(gain2_in, gain3_in));
    prod = 10'(mx >> BLCC_LO_DIV_SHIFT);
    // Times (1+bit6) then (1+bit7)
    if (mx[6]) begin
      prod = 10'(prod << 1);
    end
    if (mx[7]) begin
      prod = 10'(prod << 1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      // Matches the gain reset so no false gain change follows reset
      gain_max_out   <= GAIN_W'(BLCC_GAIN_RESET);
      lower_auto_out <= '0;
    end else begin
      gain_max_out <= mx;
      // Saturate: the field holds six bits only
      lower_auto_out <= (prod > 10'h03F) ? 6'h3F : prod[5:0];
    end
  end

endmodule // blcc_gain_max

// >>> hdl/blcc_ctrl.sv
/*
 * Black level calibration controller: threshold and control registers,
 * automatic lower and upper thresholds, average restart and rapid sweep.
 * Assumes a register master per the plain strobe port and a black level
 * value with a one-cycle update strobe from the calibration datapath.
 */
// The strobed register port was chosen for this implementation.
// Overview of operation
// RULE_01: Override bit set takes thresholds from bits 14:8 and 5:0; else automatic.
// RULE_02: Lower threshold is six bits in threshold register low bits, ADC LSB units.
// RULE_03: Lower threshold computed automatically only when bits 7 and 15 are zero.
// RULE_04: Automatic lower equals largest gain over 4, times (1+bit6)(1+bit7).
// RULE_05: Upper threshold recomputed when level jumps from below lower to above upper.
// RULE_06: New level under 64: upper is lower plus 2 plus twice excess.
// RULE_07: New level 64 to 118: upper is new level plus 4.
// RULE_08: New level above 119: upper is fixed 123.
// RULE_09: After restart sweep, upper resets to lower plus 5, or programmed field.
// RULE_10: Control bit 11 set skips the upper reset after a sweep.
// RULE_11: Control bit 15 set omits the sweep after a gain change.
// RULE_12: Software keeps control bit 14 at zero.
// RULE_13: Writing 1 to control bit 12 restarts the average; bit self-clears.
// RULE_14: Each bit 12 restart is accompanied by a rapid sweep.
// RULE_15: Mode bit zero applies calibration continuously, not intermittently.
// RULE_16: Threshold bit 15 with override clear reloads upper field after restart.
// RULE_17: Both registers are 16 bits; unlisted bits read zero.
module blcc_ctrl
  import blcc_pkg::*;
#(
  parameter int SWEEP_CYCLES = BLCC_SWEEP_CYCLES,
  parameter int INTERVAL     = 16
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  black_level_in,
  input  wire logic        level_valid_in,
  output logic      [15:0] rdata_out,
  output logic      [5:0]  lower_black_threshold_out,
  output logic      [6:0]  upper_black_threshold_out,
  output logic             avg_restart_out,
  output logic             sweep_active_out,
  output logic             cal_enable_out
);

  logic [15:0] thr_q;
  logic [15:0] ctl_q;
  logic [7:0]  gain_q [4];
  logic [5:0]  lower_q;
  logic [6:0]  upper_q;
  logic [7:0]  prev_level_q;
  logic [7:0]  largest_gain_setting;
  logic [5:0]  lower_auto;
  logic [7:0]  gmax_prev_q;
  logic [15:0] sweep_cnt_q;
  logic [15:0] int_cnt_q;
  logic        restart_req;
  logic        gain_changed;
  logic        sweep_done;
  blcc_state_t state_q;

  logic ovr;
  logic auto_hi_off;
  assign ovr         = thr_q[BLCC_THR_OVR_BIT];
  assign auto_hi_off = thr_q[BLCC_THR_AUTOHI_BIT];

  function automatic logic [6:0] blcc_sat7(input logic [8:0] v);
    blcc_sat7 = (v > 9'h07F) ? 7'h7F : v[6:0];
  endfunction

  blcc_gain_max #(
    .GAIN_W (8)
  ) u_gmax (
    .clk_in         (clk_in),
    .nrst_in        (nrst_in),
    .gain0_in       (gain_q[0]),
    .gain1_in       (gain_q[1]),
    .gain2_in       (gain_q[2]),
    .gain3_in       (gain_q[3]),
    .gain_max_out   (largest_gain_setting),
    .lower_auto_out (lower_auto)
  );

  // Register writes
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      thr_q <= BLCC_THR_RESET;
    end else if (wr_in && addr_in == BLCC_ADDR_THRES) begin
      thr_q <= wdata_in & BLCC_THR_MASK; // RULE_17
    end
  end

  // Bit 12 is never stored; bit 14 is reserved and dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctl_q <= BLCC_CTL_RESET;
    end else if (wr_in && addr_in == BLCC_ADDR_CTRL) begin
      ctl_q <= wdata_in & BLCC_CTL_MASK; // RULE_13 RULE_17
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 4; i++) begin
        gain_q[i] <= BLCC_GAIN_RESET;
      end
    end else if (wr_in) begin
      case (addr_in)
        BLCC_ADDR_GAIN0: gain_q[0] <= wdata_in[7:0];
        BLCC_ADDR_GAIN1: gain_q[1] <= wdata_in[7:0];
        BLCC_ADDR_GAIN2: gain_q[2] <= wdata_in[7:0];
        BLCC_ADDR_GAIN3: gain_q[3] <= wdata_in[7:0];
        default: ;
      endcase
    end
  end

  assign restart_req = wr_in && addr_in == BLCC_ADDR_CTRL
                       && wdata_in[BLCC_CTL_RESTART_BIT]; // RULE_13

  // Gain change seen in the first cycle the new max is present, before gmax_prev_q catches up
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gmax_prev_q <= BLCC_GAIN_RESET;
    end else begin
      gmax_prev_q <= largest_gain_setting;
    end
  end
  assign gain_changed = (gmax_prev_q != largest_gain_setting)
                        && !ctl_q[BLCC_CTL_NOSWEEP_BIT]; // RULE_11

  // Sweep sequencer
  assign sweep_done = (state_q == BLCC_ST_SWEEP)
                      && (sweep_cnt_q == 16'(SWEEP_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_q     <= BLCC_ST_IDLE;
      sweep_cnt_q <= '0;
    end else begin
      case (state_q)
        BLCC_ST_IDLE: begin
          if (restart_req || gain_changed) begin
            state_q     <= BLCC_ST_SWEEP; // RULE_14
            sweep_cnt_q <= '0;
          end
        end
        BLCC_ST_SWEEP: begin
          if (restart_req) begin
            sweep_cnt_q <= '0;
          end else if (sweep_done) begin
            state_q <= BLCC_ST_DONE;
          end else begin
            sweep_cnt_q <= sweep_cnt_q + 16'h0001;
          end
        end
        BLCC_ST_DONE: begin
          // A request landing on the last cycle must not be lost
          if (restart_req || gain_changed) begin
            state_q     <= BLCC_ST_SWEEP; // RULE_14
            sweep_cnt_q <= '0;
          end else begin
            state_q <= BLCC_ST_IDLE;
          end
        end
        default: begin
          state_q <= BLCC_ST_IDLE;
        end
      endcase
    end
  end

  // Lower threshold
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lower_q <= '0;
    end else if (ovr || auto_hi_off) begin
      lower_q <= thr_q[BLCC_THR_LO_MSB:BLCC_THR_LO_LSB]; // RULE_01 RULE_02
    end else begin
      lower_q <= lower_auto; // RULE_03 RULE_04
    end
  end

  // Upper threshold; override has priority, then post-sweep reset, then jump
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      upper_q <= 7'(BLCC_HI_RST_ADD);
    end else if (ovr) begin
      upper_q <= thr_q[BLCC_THR_HI_MSB:BLCC_THR_HI_LSB]; // RULE_01
    end else if (state_q == BLCC_ST_DONE && !ctl_q[BLCC_CTL_NOHIRST_BIT]) begin // RULE_10
      if (auto_hi_off) begin
        upper_q <= thr_q[BLCC_THR_HI_MSB:BLCC_THR_HI_LSB]; // RULE_16
      end else begin
        upper_q <= blcc_sat7(9'(lower_q) + 9'(BLCC_HI_RST_ADD)); // RULE_09
      end
    end else if (level_valid_in && prev_level_q < 8'(lower_q)
                 && black_level_in > 8'(upper_q)) begin // RULE_05
      if (black_level_in < BLCC_LVL_SMALL_LIM) begin
        upper_q <= blcc_sat7(9'(lower_q) + 9'(BLCC_HI_SMALL_ADD)
                   + 9'({(black_level_in - 8'(lower_q)), 1'b0})); // RULE_06
      end else if (black_level_in > BLCC_LVL_MID_LO && black_level_in < BLCC_LVL_MID_HI) begin
        upper_q <= blcc_sat7(9'(black_level_in) + 9'(BLCC_HI_MID_ADD)); // RULE_07
      end else if (black_level_in > BLCC_LVL_MID_HI) begin
        upper_q <= 7'(BLCC_HI_FIXED); // RULE_08
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prev_level_q <= '0;
    end else if (level_valid_in) begin
      prev_level_q <= black_level_in;
    end
  end

  // Intermittent mode gates calibration to one cycle per interval
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      int_cnt_q      <= '0;
      cal_enable_out <= 1'b0;
    end else begin
      int_cnt_q      <= (int_cnt_q == 16'(INTERVAL - 1)) ? '0 : int_cnt_q + 16'h0001;
      cal_enable_out <= !ctl_q[BLCC_CTL_MODE_BIT] || (int_cnt_q == '0); // RULE_15
    end
  end

  // Outputs
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lower_black_threshold_out <= '0;
      upper_black_threshold_out <= '0;
      avg_restart_out           <= 1'b0;
      sweep_active_out          <= 1'b0;
    end else begin
      lower_black_threshold_out <= lower_q;
      upper_black_threshold_out <= upper_q;
      avg_restart_out           <= restart_req; // RULE_13
      sweep_active_out          <= (state_q == BLCC_ST_SWEEP);
    end
  end

  // Read port: data valid the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        BLCC_ADDR_THRES:  rdata_out <= thr_q;
        BLCC_ADDR_CTRL:   rdata_out <= ctl_q; // RULE_13 RULE_17
        BLCC_ADDR_GAIN0:  rdata_out <= {8'h00, gain_q[0]};
        BLCC_ADDR_GAIN1:  rdata_out <= {8'h00, gain_q[1]};
        BLCC_ADDR_GAIN2:  rdata_out <= {8'h00, gain_q[2]};
        BLCC_ADDR_GAIN3:  rdata_out <= {8'h00, gain_q[3]};
        BLCC_ADDR_STATUS: rdata_out <= {1'b0, upper_q, state_q, lower_q};
        default:          rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule // blcc_ctrl

// >>> verif/blcc_ctrl_chk.sv
/* Checker for blcc_ctrl: port-level timing of reads, restarts, sweeps and jumps.
   Assumes it is bound to blcc_ctrl and sees only that module's ports. */
module blcc_ctrl_chk
  import blcc_pkg::*;
#(
  parameter int SWEEP_CYCLES = BLCC_SWEEP_CYCLES
) (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [7:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  black_level_in,
  input wire logic        level_valid_in,
  input wire logic [15:0] rdata_out,
  input wire logic [5:0]  lower_black_threshold_out,
  input wire logic [6:0]  upper_black_threshold_out,
  input wire logic        avg_restart_out,
  input wire logic        sweep_active_out,
  input wire logic        cal_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] prev_q;
  logic       mode_q;
  logic       ovr_q;
  int         cnt_q;
  // Previous sample starts high so no jump is assumed on the first one
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prev_q <= 8'hFF;
      mode_q <= 1'b0;
      ovr_q  <= 1'b0;
      cnt_q  <= 0;
    end else begin
      if (level_valid_in) prev_q <= black_level_in;
      if (wr_in && addr_in == BLCC_ADDR_CTRL) mode_q <= wdata_in[BLCC_CTL_MODE_BIT];
      if (wr_in && addr_in == BLCC_ADDR_THRES) ovr_q <= wdata_in[BLCC_THR_OVR_BIT];
      cnt_q <= sweep_active_out ? cnt_q + 1 : 0;
    end
  end
  sequence s_restart_wr;
    wr_in && addr_in == BLCC_ADDR_CTRL && wdata_in[BLCC_CTL_RESTART_BIT];
  endsequence
  sequence s_thr_ovr;
    wr_in && addr_in == BLCC_ADDR_THRES && wdata_in[BLCC_THR_OVR_BIT];
  endsequence
  sequence s_jump;
    level_valid_in && !ovr_q && prev_q < {2'b00, lower_black_threshold_out}
      && black_level_in > {1'b0, upper_black_threshold_out};
  endsequence
  a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside read answer");
  a_ctrl_read_mask: assert property ($past(rd_in) && $past(addr_in) == BLCC_ADDR_CTRL
    |-> (rdata_out & ~BLCC_CTL_MASK) == 16'h0000) else $error("control read shows dropped bits");
  a_restart_then_sweep: assert property (s_restart_wr |=> avg_restart_out ##1 sweep_active_out)
    else $error("restart write not followed by pulse and sweep");
  a_restart_has_cause: assert property (!(wr_in && addr_in == BLCC_ADDR_CTRL
    && wdata_in[BLCC_CTL_RESTART_BIT]) |=> !avg_restart_out)
    else $error("restart pulse without restart write");
  a_thr_override: assert property (s_thr_ovr |-> ##3
    lower_black_threshold_out == $past(wdata_in[5:0], 3)
    && upper_black_threshold_out == $past(wdata_in[14:8], 3)) else $error("override fields not taken");
  a_sweep_length: assert property ($fell(sweep_active_out) |-> cnt_q == SWEEP_CYCLES)
    else $error("sweep length wrong");
  a_cal_continuous: assert property (!mode_q && !$past(mode_q, 2) && $past(nrst_in, 2)
    |-> cal_enable_out) else $error("calibration not continuous");
  a_jump_small: assert property (s_jump ##0 (black_level_in < 8'd64) |-> ##2
    {2'b00, upper_black_threshold_out} == 9'({1'b0, $past(black_level_in, 2)} << 1) + 9'd2
    - 9'($past(lower_black_threshold_out, 2))) else $error("small jump upper wrong");
  a_jump_mid: assert property (s_jump ##0 (black_level_in > 8'd63 && black_level_in < 8'd119)
    |-> ##2 {1'b0, upper_black_threshold_out} == $past(black_level_in, 2) + 8'd4)
    else $error("mid jump upper wrong");
  a_jump_top: assert property (s_jump ##0 (black_level_in > 8'd119)
    |-> ##2 upper_black_threshold_out == 7'd123) else $error("top jump upper wrong");
endmodule // blcc_ctrl_chk

// >>> verif/blcc_ctrl_tb_top.sv
/* Testbench for blcc_ctrl: register access, thresholds, restarts, jumps, sweeps.
   Assumes the checker file is compiled first; bench drives all ports itself. */
module blcc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import blcc_pkg::*;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [7:0]  black_level_in = 8'h00;
  logic        level_valid_in = 1'b0;
  logic [15:0] rdata_out;
  logic [5:0]  lower_black_threshold_out;
  logic [6:0]  upper_black_threshold_out;
  logic        avg_restart_out;
  logic        sweep_active_out;
  logic        cal_enable_out;
  int          errors = 0;
  int          checks_done = 0;
  int          n;
  logic [7:0]  gv [4] = '{8'h20, 8'h48, 8'h90, 8'h0C};
  logic [5:0]  ge [4] = '{6'd8, 6'd36, 6'd63, 6'd3};
  logic [7:0]  jv [3] = '{8'd20, 8'd100, 8'd125};
  logic [6:0]  je [3] = '{7'd34, 7'd104, 7'd123};
  always #50 clk_in = ~clk_in;
  blcc_ctrl #(.SWEEP_CYCLES(4), .INTERVAL(16)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .black_level_in(black_level_in), .level_valid_in(level_valid_in), .rdata_out(rdata_out),
    .lower_black_threshold_out(lower_black_threshold_out),
    .upper_black_threshold_out(upper_black_threshold_out), .avg_restart_out(avg_restart_out),
    .sweep_active_out(sweep_active_out), .cal_enable_out(cal_enable_out));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask
  task automatic sample(input logic [7:0] l);
    @(posedge clk_in);
    level_valid_in <= 1'b1;
    black_level_in <= l;
    @(posedge clk_in);
    level_valid_in <= 1'b0;
    #1;
  endtask
  // Bounded wait for the sweep to end, then let the threshold update land
  task automatic settle();
    idle(2);
    n = 0;
    while (sweep_active_out !== 1'b0 && n < 100) begin
      idle(1);
      n++;
    end
    if (n >= 100) begin
      errors++;
      close_out();
    end
    idle(4);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(BLCC_ADDR_CTRL, BLCC_CTL_RESET);
    rd(BLCC_ADDR_THRES, BLCC_THR_RESET);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h0000);
    wr(BLCC_ADDR_CTRL, 16'hAFFF);
    rd(BLCC_ADDR_CTRL, 16'h8801);
    n = 0;
    for (int i = 0; i < 32; i++) begin
      idle(1);
      if (cal_enable_out === 1'b1) n++;
    end
    chk(16'(n), 16'd2);
    wr(BLCC_ADDR_THRES, 16'hFFFF);
    rd(BLCC_ADDR_THRES, 16'hFFBF);
    wr(BLCC_ADDR_THRES, 16'h5092);
    wr(BLCC_ADDR_GAIN0, 16'h0020);
    idle(4);
    chk(16'(lower_black_threshold_out), 16'h0012);
    chk(16'(upper_black_threshold_out), 16'h0050);
    wr(BLCC_ADDR_THRES, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(BLCC_ADDR_GAIN0 + 8'(i), {8'h00, gv[i]});
      idle(4);
      chk(16'(lower_black_threshold_out), 16'(ge[i]));
      wr(BLCC_ADDR_GAIN0 + 8'(i), 16'h0008);
    end
    wr(BLCC_ADDR_GAIN0, 16'h0020);
    wr(BLCC_ADDR_CTRL, 16'h1000);
    chk(16'(avg_restart_out), 16'h0001);
    settle();
    chk(16'(upper_black_threshold_out), 16'd13);
    rd(BLCC_ADDR_CTRL, 16'h0000);
    chk(16'(cal_enable_out), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      sample(8'd5);
      sample(jv[i]);
      idle(3);
      chk(16'(upper_black_threshold_out), 16'(je[i]));
    end
    sample(8'd50);
    sample(8'd126);
    idle(3);
    chk(16'(upper_black_threshold_out), 16'd123);
    wr(BLCC_ADDR_CTRL, 16'h1800);
    settle();
    chk(16'(upper_black_threshold_out), 16'd123);
    wr(BLCC_ADDR_THRES, 16'hB00A);
    wr(BLCC_ADDR_CTRL, 16'h1000);
    settle();
    chk(16'(upper_black_threshold_out), 16'h0030);
    chk(16'(lower_black_threshold_out), 16'h000A);
    wr(BLCC_ADDR_THRES, 16'h0000);
    wr(BLCC_ADDR_GAIN1, 16'h0040);
    idle(4);
    chk(16'(sweep_active_out), 16'h0001);
    settle();
    wr(BLCC_ADDR_CTRL, 16'h8000);
    wr(BLCC_ADDR_GAIN1, 16'h0008);
    n = 0;
    for (int i = 0; i < 10; i++) begin
      idle(1);
      if (sweep_active_out !== 1'b0) n++;
    end
    chk(16'(n), 16'd0);
    rd(BLCC_ADDR_STATUS, 16'h2508);
    close_out();
  end
endmodule // blcc_ctrl_tb_top

bind blcc_ctrl blcc_ctrl_chk #(.SWEEP_CYCLES(SWEEP_CYCLES)) i_chk (.clk_in(clk_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .black_level_in(black_level_in), .level_valid_in(level_valid_in), .rdata_out(rdata_out),
  .lower_black_threshold_out(lower_black_threshold_out),
  .upper_black_threshold_out(upper_black_threshold_out), .avg_restart_out(avg_restart_out),
  .sweep_active_out(sweep_active_out), .cal_enable_out(cal_enable_out));
